// File: common/act_defines.vh
// Register word indices, field positions and reset values of the channel trim bank.
`ifndef ACT_DEFINES_VH
`define ACT_DEFINES_VH
`define ACT_IDX_POWER_DOWN 8'h29
`define ACT_IDX_RANGE_SEL 8'h2a
`define ACT_IDX_OFFSET 8'h2b
`define ACT_IDX_GAIN 8'h2e
`define ACT_IDX_PHASE 8'h30
`define ACT_IDX_AVG_CTRL 8'h27
`define ACT_RST_POWER_DOWN 4'h0
`define ACT_RST_RANGE_SEL 4'hf
`define ACT_RST_OFFSET 16'h0000
`define ACT_RST_GAIN 16'h8000
`define ACT_RST_PHASE 16'h0000
`define ACT_RST_AVG_EN 1'b0
`define ACT_AVG_EN_BIT 7
`define ACT_OFFSET_LSB 8
`define ACT_GAIN_SHIFT 15
`define ACT_SAT_MAX 16'h7fff
`define ACT_SAT_MIN 16'h8000
`endif

// File: logic/act_trim_bank.v
// Channel power-down, range select and channel 0 trim registers with datapath.
//
// Implementation choice: register access over APB.
`timescale 1ns/1ns
`default_nettype none
`include "act_defines.vh"
module act_trim_bank (
    input wire clk_sys_i,
    input wire rst_i,
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [11:0] paddr_i,
    input wire [31:0] pwdata_i,
    output wire pready_o,
    output reg [31:0] prdata_o,
    output wire pslverr_o,
    input wire [3:0] conv_req_i,
    output wire [3:0] conv_start_o,
    output wire [3:0] chan_power_down_o,
    output wire [3:0] chan0_range_code_o,
    output wire chan0_range_bipolar_o,
    output reg [2:0] chan0_range_span_o,
    output wire averaging_enable_o,
    output wire [15:0] chan0_phase_o,
    input wire sample_valid_i,
    input wire [15:0] sample_i,
    output reg result_valid_o,
    output reg [15:0] result_o
);
    localparam [9:0] IDX_POWER_DOWN = {2'b00, `ACT_IDX_POWER_DOWN};
    localparam [9:0] IDX_RANGE_SEL = {2'b00, `ACT_IDX_RANGE_SEL};
    localparam [9:0] IDX_OFFSET = {2'b00, `ACT_IDX_OFFSET};
    localparam [9:0] IDX_GAIN = {2'b00, `ACT_IDX_GAIN};
    localparam [9:0] IDX_PHASE = {2'b00, `ACT_IDX_PHASE};
    localparam [9:0] IDX_AVG_CTRL = {2'b00, `ACT_IDX_AVG_CTRL};
    localparam signed [33:0] SAT_HI = 34'sd32767;
    localparam signed [33:0] SAT_LO = -34'sd32768;

    reg [3:0] power_down_q;
    reg [3:0] range_sel_q;
    reg [15:0] offset_q;
    reg [15:0] gain_q;
    reg [15:0] phase_q;
    reg avg_en_q;
    reg ready_q;
    reg [31:0] rdata_d;
    reg hit_d;
    reg [15:0] result_d;
    wire [9:0] idx;
    wire acc_phase;
    wire wr_en;
    wire rd_load;
    wire sel_power_down;
    wire sel_range_sel;
    wire sel_offset;
    wire sel_gain;
    wire sel_phase;
    wire sel_avg_ctrl;
    wire smp_take;
    wire signed [16:0] sum;
    wire signed [33:0] prod;
    wire signed [33:0] scaled;

    assign idx = paddr_i[11:2];
    assign sel_power_down = (idx == IDX_POWER_DOWN);
    assign sel_range_sel = (idx == IDX_RANGE_SEL);
    assign sel_offset = (idx == IDX_OFFSET);
    assign sel_gain = (idx == IDX_GAIN);
    assign sel_phase = (idx == IDX_PHASE);
    assign sel_avg_ctrl = (idx == IDX_AVG_CTRL);

    // The access phase has one wait state, so read data is already registered
    // when pready shows; a write lands on the edge that ends the access.
    assign acc_phase = psel_i & penable_i;
    assign wr_en = acc_phase & ready_q & pwrite_i;
    assign rd_load = acc_phase & ~ready_q & ~pwrite_i;
    assign pready_o = ready_q;
    assign pslverr_o = acc_phase & ready_q & ~hit_d;

    always @(posedge clk_sys_i) begin
        if (rst_i) begin
            ready_q <= 1'b0;
        end else begin
            ready_q <= acc_phase & ~ready_q;
        end
    end

    // Read multiplexer; reserved bits always read as zero.
    always @* begin
        hit_d = 1'b1;
        rdata_d = 32'h0000_0000;
        if (sel_power_down) begin
            rdata_d = {28'h000_0000, power_down_q};
        end else if (sel_range_sel) begin
            rdata_d = {28'h000_0000, range_sel_q};
        end else if (sel_offset) begin
            rdata_d = {8'h00, offset_q, 8'h00};
        end else if (sel_gain) begin
            rdata_d = {16'h0000, gain_q};
        end else if (sel_phase) begin
            rdata_d = {16'h0000, phase_q};
        end else if (sel_avg_ctrl) begin
            rdata_d = {24'h00_0000, avg_en_q, 7'h00};
        end else begin
            hit_d = 1'b0;
        end
    end

    always @(posedge clk_sys_i) begin
        if (rst_i) begin
            prdata_o <= 32'h0000_0000;
        end else if (rd_load) begin
            prdata_o <= rdata_d;
        end
    end

    // One register per block; each loads only on its own write.
    always @(posedge clk_sys_i) begin
        if (rst_i) begin
            power_down_q <= `ACT_RST_POWER_DOWN;
        end else if (wr_en & sel_power_down) begin
            power_down_q <= pwdata_i[3:0];
        end
    end

    always @(posedge clk_sys_i) begin
        if (rst_i) begin
            range_sel_q <= `ACT_RST_RANGE_SEL;
        end else if (wr_en & sel_range_sel) begin
            range_sel_q <= pwdata_i[3:0];
        end
    end

    always @(posedge clk_sys_i) begin
        if (rst_i) begin
            offset_q <= `ACT_RST_OFFSET;
        end else if (wr_en & sel_offset) begin
            offset_q <= pwdata_i[23:8];
        end
    end

    always @(posedge clk_sys_i) begin
        if (rst_i) begin
            gain_q <= `ACT_RST_GAIN;
        end else if (wr_en & sel_gain) begin
            gain_q <= pwdata_i[15:0];
        end
    end

    always @(posedge clk_sys_i) begin
        if (rst_i) begin
            phase_q <= `ACT_RST_PHASE;
        end else if (wr_en & sel_phase) begin
            phase_q <= pwdata_i[15:0];
        end
    end

    always @(posedge clk_sys_i) begin
        if (rst_i) begin
            avg_en_q <= `ACT_RST_AVG_EN;
        end else if (wr_en & sel_avg_ctrl) begin
            avg_en_q <= pwdata_i[`ACT_AVG_EN_BIT];
        end
    end

    assign conv_start_o = conv_req_i & ~power_down_q;
    assign chan_power_down_o = power_down_q;
    assign chan0_range_code_o = range_sel_q;
    assign chan0_range_bipolar_o = range_sel_q[0];
    assign averaging_enable_o = avg_en_q;
    assign chan0_phase_o = avg_en_q ? phase_q : 16'h0000;

    // Span index 0..7 stands for 2.5, 5, 6.25, 10, 12.5, 20, 25 and 40 V.
    always @* begin
        chan0_range_span_o = range_sel_q[3:1];
    end

    // The product of a 17-bit sum and a 17-bit gain fits in 34 bits.
    assign smp_take = sample_valid_i & ~power_down_q[0];
    assign sum = $signed({sample_i[15], sample_i}) +
                 $signed({offset_q[15], offset_q});
    assign prod = sum * $signed({1'b0, gain_q});
    assign scaled = prod >>> `ACT_GAIN_SHIFT;

    always @* begin
        if (scaled > SAT_HI) begin
            result_d = `ACT_SAT_MAX;
        end else if (scaled < SAT_LO) begin
            result_d = `ACT_SAT_MIN;
        end else begin
            result_d = scaled[15:0];
        end
    end

    always @(posedge clk_sys_i) begin
        if (rst_i) begin
            result_valid_o <= 1'b0;
            result_o <= 16'h0000;
        end else begin
            result_valid_o <= smp_take;
            if (smp_take) begin
                result_o <= result_d;
            end
        end
    end
endmodule // act_trim_bank
`default_nettype wire

// File: sim/act_trim_bank_properties.sv
// Assertion checker for the channel trim bank ports.
`timescale 1ns/1ns
`default_nettype none
module act_chk (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic [3:0] conv_req_i,
    input wire logic [3:0] conv_start_o,
    input wire logic [3:0] chan_power_down_o,
    input wire logic [3:0] chan0_range_code_o,
    input wire logic chan0_range_bipolar_o,
    input wire logic [2:0] chan0_range_span_o,
    input wire logic averaging_enable_o,
    input wire logic [15:0] chan0_phase_o,
    input wire logic sample_valid_i,
    input wire logic result_valid_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    sequence s_smp;
        sample_valid_i && !chan_power_down_o[0];
    endsequence
    chk_sleep_gate: assert property (
        conv_start_o == (conv_req_i & ~chan_power_down_o)) else $error("gate");
    chk_sleep_result: assert property (
        sample_valid_i && chan_power_down_o[0] |=> !result_valid_o)
        else $error("asleep result");
    chk_range_bipolar: assert property (
        chan0_range_bipolar_o == chan0_range_code_o[0]) else $error("bipolar");
    chk_range_span: assert property (
        chan0_range_span_o == chan0_range_code_o[3:1]) else $error("span");
    chk_range_reset: assert property (
        $fell(rst_i) |-> chan0_range_code_o == 4'hf) else $error("range rst");
    chk_result_lat: assert property (
        s_smp |=> result_valid_o) else $error("no result");
    chk_result_cause: assert property (
        result_valid_o |-> $past(sample_valid_i)) else $error("stray result");
    chk_phase_gate: assert property (
        !averaging_enable_o |-> chan0_phase_o == 16'h0000) else $error("phase");
endmodule // act_chk
bind act_trim_bank act_chk u_chk (.*);
`default_nettype wire

// File: sim/tb_act_trim_bank.sv
// Self-checking bench for the channel trim bank.
`timescale 1ns/1ns
`default_nettype none
module tb_act_trim_bank;
    logic clk_sys_i = 0, rst_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0;
    logic sample_valid_i = 0, pready_o, pslverr_o, result_valid_o, err;
    logic [11:0] paddr_i = 0;
    logic [31:0] pwdata_i = 0, prdata_o, rd;
    logic [15:0] sample_i = 0, chan0_phase_o, result_o;
    logic [3:0] conv_req_i = 0, conv_start_o, chan_power_down_o;
    logic [3:0] chan0_range_code_o;
    logic [2:0] chan0_range_span_o;
    logic chan0_range_bipolar_o, averaging_enable_o;
    int num_errors = 0, checks_done = 0, cyc = 0;
    act_trim_bank dut (.*);
    always #2 clk_sys_i = ~clk_sys_i;
    always @(posedge clk_sys_i) if (++cyc == 5000) begin
        num_errors++;
        wrap_up;
    end
    task cmp(input [31:0] g, e);
        checks_done++;
        if (g !== e) begin
            num_errors++;
            $display("unexpected at %0t: got %h exp %h", $time, g, e);
        end
    endtask
    task ap(input w, input [11:0] a, input [31:0] d);
        @(posedge clk_sys_i);
        {psel_i, pwrite_i, paddr_i, pwdata_i} <= {1'b1, w, a, d};
        @(posedge clk_sys_i) penable_i <= 1;
        do @(posedge clk_sys_i); while (pready_o !== 1'b1);
        err = pslverr_o;
        rd = prdata_o;
        {psel_i, penable_i} <= 0;
    endtask
    task rc(input [11:0] a, input [31:0] e);
        ap(0, a, 0);
        cmp(rd, e);
    endtask
    task smp(input [15:0] s, input [31:0] e);
        @(posedge clk_sys_i);
        {sample_valid_i, sample_i} <= {1'b1, s};
        @(posedge clk_sys_i) sample_valid_i <= 0;
        #1 cmp({result_valid_o, result_o}, e);
    endtask
    task t_regs;
        rc(12'h0a8, 32'h0000_000f);
        rc(12'h0b8, 32'h0000_8000);
        rc(12'h0c0, 32'h0000_0000);
        ap(1, 12'h0a4, 32'hffff_fff5);
        rc(12'h0a4, 32'h0000_0005);
        conv_req_i <= 4'hf;
        @(posedge clk_sys_i);
        cmp(conv_start_o, 32'h0000_000a);
        cmp(chan_power_down_o, 32'h0000_0005);
        ap(1, 12'h100, 32'h0000_00ff);
        cmp(err, 32'h0000_0001);
        rc(12'h100, 32'h0000_0000);
        for (int i = 0; i < 16; i++) begin
            ap(1, 12'h0a8, i);
            @(posedge clk_sys_i);
            cmp({chan0_range_span_o, chan0_range_bipolar_o}, i);
            cmp(chan0_range_code_o, i);
        end
    endtask
    task t_data;
        ap(1, 12'h0a4, 32'h0000_0000);
        ap(1, 12'h0ac, 32'h0000_10ff);
        rc(12'h0ac, 32'h0000_1000);
        ap(1, 12'h0b8, 32'h0000_4000);
        smp(16'h0064, 32'h0001_003a);
        ap(1, 12'h0b8, 32'h0000_ffff);
        smp(16'h7000, 32'h0001_7fff);
        ap(1, 12'h0a4, 32'h0000_0001);
        smp(16'h0005, 32'h0000_7fff);
        ap(1, 12'h0c0, 32'h0000_1234);
        @(posedge clk_sys_i);
        cmp(chan0_phase_o, 32'h0000_0000);
        ap(1, 12'h09c, 32'h0000_0080);
        @(posedge clk_sys_i);
        cmp(chan0_phase_o, 32'h0000_1234);
        cmp(averaging_enable_o, 32'h0000_0001);
    endtask
    task wrap_up;
        $display("errors %0d checks %0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge clk_sys_i);
        rst_i <= 0;
        t_regs;
        t_data;
        wrap_up;
    end
endmodule // tb_act_trim_bank
`default_nettype wire
